// ==== core/io_port_pkg.sv ====
// constants, pin roles and register map of the four-bit i/o port
package io_port_pkg;

   // register bus widths
   localparam int AW = 8;
   localparam int DW = 4;
   localparam int NPINS = 4;

   // register offsets
   localparam logic [AW-1:0] ADDR_MASK = 8'hE9;
   localparam logic [AW-1:0] ADDR_FLAG = 8'hED;
   localparam logic [AW-1:0] ADDR_DATA = 8'hF6;
   localparam logic [AW-1:0] ADDR_CTRL = 8'hFC;

   // field positions
   localparam int BIT_MASK = 2;
   localparam int BIT_FLAG = 1;
   localparam int BIT_DIR = 0;
   localparam int BIT_PULL = 1;

   // reset values
   localparam logic RST_DIR = 1'b0;
   localparam logic RST_PULL = 1'b0;
   localparam logic RST_MASK = 1'b0;
   localparam logic RST_FLAG = 1'b0;
   localparam logic [DW-1:0] RST_DATA = 4'h0;

   // sampling clock divider default, system clocks per sampling period
   localparam int SAMPLE_DIV_DEF = 16;

   // pin role codes, two bits per pin
   localparam logic [1:0] ROLE_IO = 2'h0;
   localparam logic [1:0] ROLE_IN = 2'h1;
   localparam logic [1:0] ROLE_SER = 2'h2;

   // pin function set, {pin3, pin2, pin1, pin0} for each of 14 builds
   function automatic logic [7:0] role_map(input int cfg);
      case (cfg)
         1: role_map = 8'h00;
         2: role_map = 8'h40;
         3: role_map = 8'hAA;
         4: role_map = 8'h2A;
         5: role_map = 8'h6A;
         6: role_map = 8'h22;
         7: role_map = 8'h62;
         8: role_map = 8'hAA;
         9: role_map = 8'h2A;
         10: role_map = 8'h6A;
         11: role_map = 8'hA2;
         12: role_map = 8'hA6;
         13: role_map = 8'h22;
         14: role_map = 8'h62;
         default: role_map = 8'h00;
      endcase
   endfunction

   // one bit per pin that holds the given role
   function automatic logic [NPINS-1:0] role_mask(input logic [7:0] roles,
                                                   input logic [1:0] code);
      logic [NPINS-1:0] m;
      m = '0;
      for (int i = 0; i < NPINS; i++) begin
         m[i] = (roles[2*i +: 2] == code);
      end
      return m;
   endfunction

endpackage

// ==== core/pin_event_filter.sv ====
// input synchroniser, noise filter and falling-edge detector for one pin
`timescale 1ns/1ps
module pin_event_filter #(
   parameter bit FILTER = 1'b0
) (
   input wire logic clk,      // system clock
   input wire logic rst_n,    // async reset, active low
   input wire logic half_en,  // half sampling period tick
   input wire logic full_en,  // full sampling period tick
   input wire logic pin,      // raw pin level
   output logic fall          // one-cycle pulse on accepted fall
);

   logic s1_r, s2_r, s3_r, lvl_r, fall_r;
   logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt, fall_nxt, smp_en;

   ////////////////////////////////////////////////////////////////////////
   // sampling chain and filtered level
   always_comb begin
      smp_en = FILTER ? half_en : full_en;
      s1_nxt = s1_r;
      s2_nxt = s2_r;
      s3_nxt = s3_r;
      // R19: two-stage sync on sampling clock
      if (smp_en) begin
         s1_nxt = pin;
         s2_nxt = s1_r;
         s3_nxt = s2_r;
      end
      // R13: two agreeing half-period samples
      if (FILTER) begin
         lvl_nxt = (s2_r == s3_r) ? s2_r : lvl_r;
      end else begin
         lvl_nxt = s2_r;
      end
      fall_nxt = lvl_r & ~lvl_nxt;
   end

   // registers, idle level high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         lvl_r <= 1'b1;
         fall_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign fall = fall_r;

   // R13: a filtered fall needs two low samples
   a_filter_two_low: assert property (@(posedge clk) // R13
      disable iff (!rst_n)
      (FILTER && fall) |-> $past(s2_r) == 1'b0 && $past(s3_r) == 1'b0)
      else $error("filtered fall without two low samples");

endmodule

// ==== core/four_bit_io_port.sv ====
// four-bit general-purpose bidirectional port with input interrupt
//
// Function
// R1: four bits share one direction bit
// R2: direction 0 leaves pins high impedance inputs
// R3: direction 1 drives stored data bits
// R4: read gives register in output, pins in input
// R5: reset clears direction bit, pins inputs
// R6: serial and input-only pins ignore direction
// R7: pull-ups on only when enabled and input
// R8: reset clears pull-up enable bit
// R9: input-only fitted pull-ups always on
// R10: fixed pin set of 14; bidirectional no interrupt
// R11: per-bit build choice push-pull or open-drain
// R12: interrupt only on pin 1 or 3 input-only
// R13: filter rejects short lows, accepts long lows
// R14: noise filter chosen per pin at build
// R15: enabled falling edge sets interrupt flag
// R16: reading interrupt flag clears it afterwards
// R17: data writes stored also in input mode
// R18: mask bit enables at 1, reset clears
// R19: interrupt inputs synchronised before edge detect
// R20: build options are fixed synthesis parameters
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module four_bit_io_port #(
   // R20: build-time options as parameters
   parameter int PIN_CONFIG = 1,
   parameter logic [3:0] OPEN_DRAIN = 4'h0,
   parameter logic [3:0] PULLUP_FIT = 4'h0,
   parameter logic [3:0] INT_SELECT = 4'h0,
   parameter logic [3:0] FILTER_FIT = 4'h0,
   parameter int SAMPLE_DIV = io_port_pkg::SAMPLE_DIV_DEF
) (
   input wire logic clk,                           // system clock
   input wire logic rst_n,                         // async reset
   input wire logic [io_port_pkg::AW-1:0] addr,    // register address
   input wire logic [io_port_pkg::DW-1:0] wdata,   // write data
   input wire logic wr,                            // write strobe
   input wire logic rd,                            // read strobe
   output logic [io_port_pkg::DW-1:0] rdata,       // read data, next cycle
   input wire logic [io_port_pkg::NPINS-1:0] pin_i,      // pin levels
   output logic [io_port_pkg::NPINS-1:0] pin_o,          // pin out level
   output logic [io_port_pkg::NPINS-1:0] pin_oe_n,       // low = driving
   output logic [io_port_pkg::NPINS-1:0] pullup_on,      // pull-up active
   input wire logic [io_port_pkg::NPINS-1:0] ser_dout,   // serial out data
   input wire logic [io_port_pkg::NPINS-1:0] ser_drive,  // serial drives
   output logic [io_port_pkg::NPINS-1:0] ser_din,        // serial in data
   output logic port_irq                           // input interrupt
);
   import io_port_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin roles from the fixed build choice
   // R10: one of 14 pin function sets
   localparam logic [7:0] ROLES = role_map(PIN_CONFIG);
   localparam logic [NPINS-1:0] IO_M = role_mask(ROLES, ROLE_IO);
   localparam logic [NPINS-1:0] IN_M = role_mask(ROLES, ROLE_IN);
   localparam logic [NPINS-1:0] SER_M = role_mask(ROLES, ROLE_SER);
   // R12: interrupt only on pins 1 and 3, input-only
   localparam logic [NPINS-1:0] INT_M = INT_SELECT & IN_M & 4'hA;
   // R11: open-drain drives only low
   localparam logic [NPINS-1:0] PP_M = IO_M & ~OPEN_DRAIN;
   // R9: fitted input-only pull-ups from reset on
   localparam logic [NPINS-1:0] IN_PULL = IN_M & PULLUP_FIT;
   localparam int CW = (SAMPLE_DIV > 2) ? $clog2(SAMPLE_DIV) : 1;
   localparam logic [CW-1:0] DIV_LAST = CW'(SAMPLE_DIV - 1);
   localparam logic [CW-1:0] DIV_HALF = CW'(SAMPLE_DIV / 2 - 1);

   // control state
   logic dir_r, pull_r, mask_r, flag_r;
   logic dir_nxt, pull_nxt, mask_nxt, flag_nxt;
   logic [DW-1:0] data_r, data_nxt, rdata_r, rdata_nxt;
   // pin output state
   logic [NPINS-1:0] pin_o_r, oe_n_r, pull_on_r, ser_din_r;
   logic [NPINS-1:0] pin_o_nxt, oe_n_nxt, pull_on_nxt, ser_din_nxt;
   // sampling divider
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic half_en, full_en;
   // interrupt events
   logic [NPINS-1:0] fall;
   logic fall_any, set_flag, rd_flag;

   ////////////////////////////////////////////////////////////////////////
   // sampling clock divider, one-cycle enables
   always_comb begin
      cnt_nxt = (cnt_r == DIV_LAST) ? '0 : cnt_r + 1'b1;
      full_en = (cnt_r == DIV_LAST);
      half_en = full_en | (cnt_r == DIV_HALF);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-pin interrupt detectors on capable pins only
   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         if (INT_M[g]) begin : g_int
            // R14: filter fitted per pin
            pin_event_filter #(
               .FILTER(FILTER_FIT[g])
            ) u_filt (
               .clk(clk),
               .rst_n(rst_n),
               .half_en(half_en),
               .full_en(full_en),
               .pin(pin_i[g]),
               .fall(fall[g])
            );
         end else begin : g_none
            // R10: bidirectional and serial pins never interrupt
            assign fall[g] = 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // register file next values
   always_comb begin
      dir_nxt = dir_r;
      pull_nxt = pull_r;
      mask_nxt = mask_r;
      data_nxt = data_r;
      flag_nxt = flag_r;
      fall_any = |fall;
      rd_flag = rd && (addr == ADDR_FLAG);
      // R15: edge counts only while mask enabled
      set_flag = fall_any && mask_r;
      if (wr) begin
         case (addr)
            ADDR_CTRL: begin
               // R1: one direction bit for all four
               dir_nxt = wdata[BIT_DIR];
               pull_nxt = wdata[BIT_PULL];
            end
            ADDR_MASK: begin
               // R18: 1 enables, 0 masks
               mask_nxt = wdata[BIT_MASK];
            end
            ADDR_DATA: begin
               // R17: stored whatever the direction
               data_nxt = wdata;
            end
            default: begin
               data_nxt = data_r;
            end
         endcase
      end
      // R16: read clears flag, a new edge wins
      if (rd_flag) begin
         flag_nxt = 1'b0;
      end
      // R15: set flag on accepted edge
      if (set_flag) begin
         flag_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      if (rd) begin
         case (addr)
            ADDR_CTRL: begin
               rdata_nxt[BIT_DIR] = dir_r;
               rdata_nxt[BIT_PULL] = pull_r;
            end
            ADDR_MASK: begin
               rdata_nxt[BIT_MASK] = mask_r;
            end
            ADDR_FLAG: begin
               rdata_nxt[BIT_FLAG] = flag_r;
            end
            ADDR_DATA: begin
               // R4: register in output mode, pins otherwise
               rdata_nxt = (dir_r ? (data_r & IO_M) : '0) |
                           (pin_i & ~(dir_r ? IO_M : 4'h0));
            end
            default: begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive, pull-up and serial input next values
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (IO_M[i]) begin
            // R2: input mode leaves pin undriven
            // R3: output mode drives the stored bit
            // R11: open-drain releases for a 1
            pin_o_nxt[i] = PP_M[i] ? data_r[i] : 1'b0;
            oe_n_nxt[i] = ~(dir_r & (PP_M[i] | ~data_r[i]));
            // R7: pull-up only in input mode
            pull_on_nxt[i] = PULLUP_FIT[i] & pull_r & ~dir_r;
         end else if (SER_M[i]) begin
            // R6: serial pins follow the serial unit
            pin_o_nxt[i] = ser_dout[i];
            oe_n_nxt[i] = ~ser_drive[i];
            pull_on_nxt[i] = 1'b0;
         end else begin
            // R6: input-only never driven
            // R9: fitted pull-up permanently on
            pin_o_nxt[i] = 1'b0;
            oe_n_nxt[i] = 1'b1;
            pull_on_nxt[i] = IN_PULL[i];
         end
      end
      ser_din_nxt = pin_i & SER_M;
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // R5: pins come up as inputs
         dir_r <= RST_DIR;
         // R8: pull-up enable cleared
         pull_r <= RST_PULL;
         // R18: interrupt masked after reset
         mask_r <= RST_MASK;
         flag_r <= RST_FLAG;
         data_r <= RST_DATA;
         rdata_r <= '0;
         pin_o_r <= '0;
         oe_n_r <= '1;
         pull_on_r <= IN_PULL;
         ser_din_r <= '0;
      end else begin
         dir_r <= dir_nxt;
         pull_r <= pull_nxt;
         mask_r <= mask_nxt;
         flag_r <= flag_nxt;
         data_r <= data_nxt;
         rdata_r <= rdata_nxt;
         pin_o_r <= pin_o_nxt;
         oe_n_r <= oe_n_nxt;
         pull_on_r <= pull_on_nxt;
         ser_din_r <= ser_din_nxt;
      end
   end

   // outputs
   assign rdata = rdata_r;
   assign pin_o = pin_o_r;
   assign pin_oe_n = oe_n_r;
   assign pullup_on = pull_on_r;
   assign ser_din = ser_din_r;
   assign port_irq = flag_r & mask_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_input_hiz: assert property (@(posedge clk) disable iff (!rst_n) // R2
      !dir_r |=> (pin_oe_n & IO_M) == IO_M)
      else $error("bidirectional pin driven in input mode");

   a_output_drive: assert property (@(posedge clk) disable iff (!rst_n) // R3
      dir_r |=> ((~pin_oe_n & PP_M) == PP_M) &&
                ((pin_o & PP_M) == ($past(data_r) & PP_M)))
      else $error("output mode does not drive stored data");

   a_read_mux: assert property (@(posedge clk) disable iff (!rst_n) // R4
      (rd && addr == ADDR_DATA && dir_r) |=>
         (rdata & IO_M) == ($past(data_r) & IO_M))
      else $error("output mode read not from register");

   a_read_pins: assert property (@(posedge clk) disable iff (!rst_n) // R4
      (rd && addr == ADDR_DATA && !dir_r) |=> rdata == $past(pin_i))
      else $error("input mode read not from pins");

   a_special_pins: assert property (@(posedge clk) disable iff (!rst_n) // R6
      $changed(dir_r) |=> ((pin_oe_n & IN_M) == IN_M) &&
         ((pin_oe_n & SER_M) == (~$past(ser_drive) & SER_M)))
      else $error("special pin follows the direction bit");

   a_pull_out_off: assert property (@(posedge clk) disable iff (!rst_n) // R7
      dir_r |=> (pullup_on & IO_M) == 4'h0)
      else $error("pull-up on in output mode");

   a_pull_in_on: assert property (@(posedge clk) disable iff (!rst_n) // R7
      (!dir_r && pull_r) |=> (pullup_on & IO_M) == (PULLUP_FIT & IO_M))
      else $error("enabled pull-up missing in input mode");

   a_input_pullup: assert property (@(posedge clk) disable iff (!rst_n) // R9
      (pullup_on & IN_M) == IN_PULL)
      else $error("input-only pull-up not permanent");

   a_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // R15
      (fall_any && mask_r) |=> flag_r && port_irq == mask_r)
      else $error("enabled edge did not set flag");

   a_flag_masked: assert property (@(posedge clk) disable iff (!rst_n) // R15
      (!mask_r && !flag_r) |=> !flag_r)
      else $error("flag set while masked");

   a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n) // R16
      (rd_flag && flag_r && !set_flag) |=> !flag_r ##0 rdata[BIT_FLAG])
      else $error("flag read did not clear after returning 1");

   a_data_store: assert property (@(posedge clk) disable iff (!rst_n) // R17
      (wr && addr == ADDR_DATA) |=> data_r == $past(wdata))
      else $error("port data write not stored");

   c_flag_raised: cover property (@(posedge clk) disable iff (!rst_n)
      set_flag ##1 rd_flag);
   c_set_on_read: cover property (@(posedge clk) disable iff (!rst_n)
      set_flag && rd_flag);
   c_dir_toggle: cover property (@(posedge clk) disable iff (!rst_n)
      !dir_r ##1 dir_r ##[1:8] !dir_r);

endmodule

// ==== verification/ext_circuit.sv ====
// behavioural model of the circuitry wired to the four port pins
`timescale 1ns/1ps
module ext_circuit (
   input wire logic clk,             // system clock
   input wire logic [3:0] pin_o,     // port output level
   input wire logic [3:0] pin_oe_n,  // port drive enable, low = driving
   input wire logic [3:0] pullup_on, // port pull-up active
   input wire logic [3:0] ext_en,    // outside driver active
   input wire logic [3:0] ext_val,   // outside driver level
   output logic [3:0] pin_lvl        // resolved wire level
);
   logic float_r;

   ////////////////////////////////////////////////////////////////////////
   // undriven wire without pull-up shows a changing pattern
   always_ff @(posedge clk) begin
      float_r <= (float_r === 1'b1) ? 1'b0 : 1'b1;
   end

   // wire level from port drive, outside drive, then pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pin_oe_n[i] === 1'b0) begin
            pin_lvl[i] = pin_o[i];
         end else if (ext_en[i]) begin
            pin_lvl[i] = ext_val[i];
         end else if (pullup_on[i] === 1'b1) begin
            pin_lvl[i] = 1'b1;
         end else begin
            pin_lvl[i] = float_r;
         end
      end
   end
endmodule

// ==== verification/tb.sv ====
// self-checking bench of the four-bit port: registers, pins, interrupt
`timescale 1ns/1ps
module tb;
   import io_port_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [AW-1:0] addr = '0;
   logic [DW-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DW-1:0] rdata;
   logic [3:0] pin_i, pin_o, pin_oe_n, pullup_on, ser_din;
   logic port_irq;
   logic [3:0] ext_en = 4'h0;
   logic [3:0] ext_val = 4'h0;
   logic [3:0] ser_dout = 4'h0;
   logic [3:0] ser_drive = 4'h0;
   int failures = 0;
   int check_count = 0;

   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // pins 0..2 bidirectional, pin 3 input-only with filtered interrupt
   // sampling divider left at its default of 16 system clocks
   four_bit_io_port #(.PIN_CONFIG(2), .OPEN_DRAIN(4'h4), .PULLUP_FIT(4'hF),
      .INT_SELECT(4'h8), .FILTER_FIT(4'h8)) uut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .ser_dout(ser_dout),
      .ser_drive(ser_drive), .ser_din(ser_din), .port_irq(port_irq));

   ext_circuit ext (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val),
      .pin_lvl(pin_i));

   ////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [3:0] got, input logic [3:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one-cycle register write
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // one-cycle read, data checked in the following cycle
   task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp,
                         input string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, what);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // reset state of controls and pins
   task automatic t_reset();
      #1;
      chk(pin_oe_n, 4'hF, "oe after reset");
      chk(pullup_on, 4'h8, "pull-ups after reset");
      rd_chk(ADDR_CTRL, 4'h0, "ctrl reset");
      rd_chk(ADDR_MASK, 4'h0, "mask reset");
      rd_chk(ADDR_FLAG, 4'h0, "flag reset");
      rd_chk(8'h00, 4'h0, "unmapped read");
      $display("test reset done");
   endtask

   // input mode reads pins, data write stored silently
   task automatic t_input();
      ext_en <= 4'hF;
      ext_val <= 4'hA;
      wr_reg(ADDR_DATA, 4'h5);
      idle(2);
      chk(pin_oe_n, 4'hF, "input mode oe");
      rd_chk(ADDR_DATA, 4'hA, "input read");
      ext_en <= 4'h0;
      idle(2);
      $display("test input done");
   endtask

   task automatic t_output();
      logic [3:0] d;
      wr_reg(ADDR_CTRL, 4'h1);
      for (int k = 0; k < 2; k++) begin
         d = (k == 0) ? 4'h5 : 4'hA;
         if (k == 1) wr_reg(ADDR_DATA, d);
         idle(2);
         chk(pin_oe_n, {1'b1, d[2], 2'b00}, "output oe");
         chk({1'b0, pin_o[2:0]}, {2'b00, d[1:0]}, "output level");
         rd_chk(ADDR_DATA, {1'b1, d[2:0]}, "output read");
      end
      // serial unit requests must not reach non-serial pins
      @(posedge clk);
      ser_drive <= 4'hF;
      ser_dout <= 4'h5;
      idle(2);
      chk(pin_oe_n, 4'h8, "serial drive ignored");
      chk(pin_o, 4'h2, "serial data ignored");
      chk(ser_din, 4'h0, "no serial input pins");
      @(posedge clk);
      ser_drive <= 4'h0;
      ser_dout <= 4'h0;
      wr_reg(ADDR_CTRL, 4'h3);
      idle(2);
      chk(pullup_on, 4'h8, "pull-up off in output");
      rd_chk(ADDR_CTRL, 4'h3, "ctrl read");
      wr_reg(ADDR_CTRL, 4'h2);
      idle(2);
      chk(pullup_on, 4'hF, "pull-up on in input");
      chk(pin_oe_n, 4'hF, "back to input");
      wr_reg(ADDR_CTRL, 4'h0);
      idle(2);
      chk(pullup_on, 4'h8, "pull-up off by bit");
      $display("test output done");
   endtask

   // drive pin p low for n cycles, then release it and idle 40 cycles
   task automatic pulse_low(input int p, input int n);
      ext_en[p] <= 1'b1;
      ext_val[p] <= 1'b0;
      repeat (n) @(posedge clk);
      ext_en[p] <= 1'b0;
      idle(40);
   endtask

   task automatic t_irq();
      int n;
      wr_reg(ADDR_MASK, 4'h4);
      rd_chk(ADDR_MASK, 4'h4, "mask read");
      ext_en[3] <= 1'b1;
      ext_val[3] <= 1'b0;
      n = 0;
      while (port_irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      // a missing interrupt ends the run here
      if (port_irq !== 1'b1) begin
         failures++;
         $display("BAD %0t interrupt wait timed out", $time);
         end_of_test();
      end
      chk({3'b0, port_irq}, 4'h1, "irq raised");
      rd_chk(ADDR_FLAG, 4'h2, "flag set");
      rd_chk(ADDR_FLAG, 4'h0, "flag read-cleared");
      chk({3'b0, port_irq}, 4'h0, "irq dropped");
      ext_en[3] <= 1'b0;
      idle(40);
      pulse_low(3, 1);
      rd_chk(ADDR_FLAG, 4'h0, "glitch rejected");
      pulse_low(3, 30);
      rd_chk(ADDR_FLAG, 4'h2, "long low taken");
      pulse_low(1, 30);
      rd_chk(ADDR_FLAG, 4'h0, "bidir pin no irq");
      wr_reg(ADDR_MASK, 4'h0);
      pulse_low(3, 30);
      chk({3'b0, port_irq}, 4'h0, "masked irq");
      rd_chk(ADDR_FLAG, 4'h0, "masked edge lost");
      $display("test irq done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_input();
      t_output();
      t_irq();
      end_of_test();
   end
endmodule
